// ==== logic/timer_out_ctl.sv ====
// timer output control, valid edge selection and count clock selection with apb registers
//
// Design decision made here: register access over APB.
`default_nettype none

module timer_out_ctl (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        run_mode_hi,
    input  wire logic        run_mode_lo,
    input  wire logic        primary_match,
    input  wire logic        secondary_match,
    input  wire logic        interval_timer_tick,
    input  wire logic        primary_input_pin,
    input  wire logic        secondary_input_pin,
    output logic             timer_output_pin,
    output logic             count_tick,
    output logic             counter_clear_start,
    output logic             primary_valid_edge,
    output logic             secondary_valid_edge,
    output logic             primary_match_irq,
    output logic             secondary_match_irq
);

    timer_out_pkg::ctl_state_s st_r;
    timer_out_pkg::ctl_state_s st_nxt;

    logic [1:0] run_mode;
    logic       running;
    logic       setup_ph;
    logic       wr_en;
    logic       wr_presc;
    logic       wr_selc;
    logic       wr_outc;
    logic [7:0] wbyte;
    logic       sw_trigger;
    logic       sample_en;
    logic       hold_filters;
    logic       prime_low;
    logic [2:0] clk_code;
    logic       p_edge;
    logic       s_edge;
    logic       oneshot_ok;
    logic       p_toggle;
    logic       s_toggle;

    // index decode used for both the read and the write path
    function automatic logic hit(input logic [31:0] addr, input logic [31:0] idx);
        hit = (addr[timer_out_pkg::IDX_W+1:2] == idx[timer_out_pkg::IDX_W-1:0]) &&
              (addr[1:0] == 2'h0);
    endfunction

    assign run_mode = {run_mode_hi, run_mode_lo};
    assign running  = (run_mode != timer_out_pkg::MODE_STOP);
    assign setup_ph = psel && !penable;
    assign wr_en    = psel && penable && pwrite && pstrb[0];
    assign wr_presc = wr_en && hit(paddr, timer_out_pkg::PRESCALER_IDX);
    assign wr_selc  = wr_en && hit(paddr, timer_out_pkg::SELECTOR_IDX);
    assign wr_outc  = wr_en && hit(paddr, timer_out_pkg::OUTCTL_IDX);
    assign wbyte    = pwdata[7:0];
    assign pready   = 1'b1;

    // a one written to the trigger bit while the counter runs clears and starts it; in stop mode it does nothing
    assign sw_trigger = wr_outc && wbyte[timer_out_pkg::OSPT_BIT] && running;

    // pins are sampled at fxx/4, so an external clock must hold longer than two of those
    assign sample_en    = (st_r.div[1:0] == timer_out_pkg::SAMPLE_PHASE);
    assign hold_filters = !running;
    // only the first enable after reset sees a high pin as a rise
    assign prime_low    = !st_r.ran_before;

    edge_filter u_primary (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .pin_in     (primary_input_pin),
        .sample_en  (sample_en),
        .hold       (hold_filters),
        .prime_low  (prime_low),
        .edge_sel   (st_r.presc[timer_out_pkg::PES_LO+:2]),
        .valid_edge (p_edge),
        .level      ()
    );

    edge_filter u_secondary (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .pin_in     (secondary_input_pin),
        .sample_en  (sample_en),
        .hold       (hold_filters),
        .prime_low  (prime_low),
        .edge_sel   (st_r.presc[timer_out_pkg::SES_LO+:2]),
        .valid_edge (s_edge),
        .level      ()
    );

    assign primary_valid_edge   = p_edge;
    assign secondary_valid_edge = s_edge;

    // count clock selection; the prohibited code gives no tick
    assign clk_code = {st_r.selc[timer_out_pkg::GRP_BIT], st_r.presc[timer_out_pkg::CS_LO+:2]};
    always_comb begin
        case (clk_code)
            timer_out_pkg::CLK_FXX:   count_tick = running;
            timer_out_pkg::CLK_DIV4:  count_tick = running && (st_r.div[1:0] == 2'h3);
            timer_out_pkg::CLK_TICK:  count_tick = running && interval_timer_tick;
            timer_out_pkg::CLK_PIN:   count_tick = running && p_edge;
            timer_out_pkg::CLK_DIV2:  count_tick = running && st_r.div[0];
            timer_out_pkg::CLK_DIV8:  count_tick = running && (st_r.div[2:0] == 3'h7);
            timer_out_pkg::CLK_DIV16: count_tick = running && (st_r.div == 4'hF);
            default:                  count_tick = 1'b0;
        endcase
    end

    // one-shot is honoured in free-running and edge clear modes only
    assign oneshot_ok = st_r.outc[timer_out_pkg::OSPE_BIT] &&
                        (run_mode == timer_out_pkg::MODE_FREE ||
                         run_mode == timer_out_pkg::MODE_EDGE);
    // match toggles gated by inversion enables and one-shot arming
    assign s_toggle = running && secondary_match && st_r.outc[timer_out_pkg::SINV_BIT] &&
                      (!oneshot_ok || st_r.armed);
    assign p_toggle = running && primary_match && st_r.outc[timer_out_pkg::PINV_BIT] &&
                      (!oneshot_ok || st_r.armed);

    // next state of registers, output level, divider and bus answer
    always_comb begin
        st_nxt = st_r;
        if (wr_presc) begin
            st_nxt.presc = wbyte & timer_out_pkg::PRESC_MASK;
        end
        if (wr_selc) begin
            st_nxt.selc = wbyte & timer_out_pkg::SELECTOR_MASK;
        end
        // trigger bits are never stored, so they read zero
        if (wr_outc) begin
            st_nxt.outc = wbyte & timer_out_pkg::OUTCTL_MASK;
        end
        // divider only runs with the counter so that ticks start in a known phase
        st_nxt.div = running ? st_r.div + 4'h1 : '0;
        if (running) begin
            st_nxt.ran_before = 1'b1;
        end
        // one-shot arming: trigger or edge arms, primary match ends the pulse
        if (!oneshot_ok) begin
            st_nxt.armed = 1'b0;
        end else if (sw_trigger ||
                     (run_mode == timer_out_pkg::MODE_EDGE && p_edge)) begin
            st_nxt.armed = 1'b1;
        end else if (primary_match) begin
            st_nxt.armed = 1'b0;
        end
        // both matches in one cycle cancel each other when both inversion enables are set
        st_nxt.level = st_r.level ^ p_toggle ^ s_toggle;
        // level triggers act only on a written one; 11 ignored
        if (wr_outc) begin
            case ({wbyte[timer_out_pkg::FHIGH_BIT], wbyte[timer_out_pkg::FLOW_BIT]})
                2'b10:   st_nxt.level = 1'b1;
                2'b01:   st_nxt.level = 1'b0;
                default: st_nxt.level = st_nxt.level;
            endcase
        end
        // pin held low while the output is disabled
        st_nxt.pin = st_nxt.outc[timer_out_pkg::TOE_BIT] && st_nxt.level;
        // clear and start on trigger, primary edge or primary match by mode
        st_nxt.clr_start = sw_trigger ||
                           (run_mode == timer_out_pkg::MODE_EDGE && p_edge) ||
                           (run_mode == timer_out_pkg::MODE_MATCH && primary_match);
        // interrupts follow matches whatever the inversion enables
        st_nxt.pirq = running && primary_match;
        st_nxt.sirq = running && secondary_match;
        // read data is taken in the setup phase and stands through the access phase
        if (setup_ph) begin
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata  = '0;
            if (hit(paddr, timer_out_pkg::PRESCALER_IDX)) begin
                st_nxt.prdata[7:0] = st_r.presc;
            end else if (hit(paddr, timer_out_pkg::SELECTOR_IDX)) begin
                st_nxt.prdata[7:0] = st_r.selc;
            end else if (hit(paddr, timer_out_pkg::OUTCTL_IDX)) begin
                st_nxt.prdata[7:0] = st_r.outc;
            end else if (hit(paddr, timer_out_pkg::STATUS_IDX)) begin
                st_nxt.prdata[3:0] = {st_r.ran_before, st_r.armed, st_r.pin, st_r.level};
            end else begin
                st_nxt.pslverr = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r       <= '0;
            st_r.presc <= timer_out_pkg::PRESC_RST;
            st_r.selc  <= timer_out_pkg::SELECTOR_RST;
            st_r.outc  <= timer_out_pkg::OUTCTL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata              = st_r.prdata;
    assign pslverr             = st_r.pslverr && psel && penable;
    assign timer_output_pin    = st_r.pin;
    assign counter_clear_start = st_r.clr_start;
    assign primary_match_irq   = st_r.pirq;
    assign secondary_match_irq = st_r.sirq;

    // ---------------- assertions ----------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence outc_read_s;
        setup_ph && !pwrite && hit(paddr, timer_out_pkg::OUTCTL_IDX);
    endsequence

    sequence force_high_s;
        wr_outc && wbyte[3:2] == 2'b10 && wbyte[timer_out_pkg::TOE_BIT] &&
            st_r.outc[timer_out_pkg::TOE_BIT];
    endsequence

    sequence quiet_out_s;
        !wr_outc && st_r.outc[timer_out_pkg::TOE_BIT] && !oneshot_ok;
    endsequence

    trig_reads_zero_a: assert property (outc_read_s |=> prdata[6] == 1'b0)
        else $error("trigger bit read back as one");
    level_reads_zero_a: assert property (outc_read_s |=> prdata[3:2] == 2'b00)
        else $error("level trigger bits read back nonzero");
    trig_clears_a: assert property (sw_trigger |=> counter_clear_start)
        else $error("trigger write did not clear and start");
    pin_low_off_a: assert property (!st_r.outc[timer_out_pkg::TOE_BIT]
            |-> !timer_output_pin)
        else $error("pin high while output disabled");
    force_high_a: assert property (force_high_s |=> timer_output_pin ##1 1'b1)
        else $error("force high did not raise pin");
    primary_toggle_a: assert property (quiet_out_s and (running && primary_match &&
            !secondary_match && st_r.outc[timer_out_pkg::PINV_BIT])
            |=> timer_output_pin != $past(timer_output_pin))
        else $error("primary match did not toggle pin");
    secondary_toggle_a: assert property (quiet_out_s and (running &&
            secondary_match && !primary_match && st_r.outc[timer_out_pkg::SINV_BIT])
            |=> timer_output_pin != $past(timer_output_pin))
        else $error("secondary match did not toggle pin");
    no_invert_a: assert property (!wr_outc && !st_r.outc[timer_out_pkg::PINV_BIT] &&
            !st_r.outc[timer_out_pkg::SINV_BIT] |=> $stable(timer_output_pin))
        else $error("pin changed with inversions disabled");
    primary_irq_a: assert property (running && primary_match |=> primary_match_irq)
        else $error("primary match interrupt missing");
    secondary_irq_a: assert property (running && secondary_match
            |=> secondary_match_irq)
        else $error("secondary match interrupt missing");
    stop_no_tick_a: assert property (!running |-> !count_tick)
        else $error("count tick while stopped");
    div4_tick_a: assert property (running && clk_code == timer_out_pkg::CLK_DIV4 &&
            count_tick ##1 (running && clk_code == timer_out_pkg::CLK_DIV4)[*3]
            |=> count_tick)
        else $error("fxx/4 tick spacing wrong");

endmodule

`default_nettype wire

// ==== logic/timer_out_pkg.sv ====
// constants, field layouts and state carriers of the timer output and count clock block
// Behaviour
// - software one-shot trigger bit reads zero
// - trigger write clears and starts counter while running
// - one-shot only in free-run or edge modes
// - secondary match toggles pin when enabled
// - secondary match interrupt raised regardless of enable
// - primary match toggles pin when enabled
// - primary match interrupt raised regardless of enable
// - level bits: 01 low, 10 high, 11 ignored
// - level bits act only when written one
// - level trigger bits always read zero
// - output disabled holds pin low
// - first enable with high pin reports rise
// - secondary edge select: fall, rise, both
// - primary edge select: fall, rise, both
// - count clock chosen from three select bits
// - mode bits: stop, free, edge clear, match clear
// - edge valid after two equal samples
`default_nettype none

package timer_out_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [31:0] PRESCALER_IDX = 32'h0FFFF617;
    localparam logic [31:0] SELECTOR_IDX  = 32'hFFFFF30A;
    localparam logic [31:0] OUTCTL_IDX    = 32'hFFFFF619;
    localparam logic [31:0] STATUS_IDX    = 32'hFFFFF61A;
    localparam int          IDX_W         = 12;

    // output control fields
    localparam int TOE_BIT   = 0;
    localparam int PINV_BIT  = 1;
    localparam int FLOW_BIT  = 2;
    localparam int FHIGH_BIT = 3;
    localparam int SINV_BIT  = 4;
    localparam int OSPE_BIT  = 5;
    localparam int OSPT_BIT  = 6;

    // prescaler / edge fields and selector field
    localparam int CS_LO   = 0;
    localparam int PES_LO  = 4;
    localparam int SES_LO  = 6;
    localparam int GRP_BIT = 1;

    // storable bits; all others are reserved or trigger bits and read zero
    localparam logic [7:0] OUTCTL_MASK   = 8'h33;
    localparam logic [7:0] PRESC_MASK    = 8'hF3;
    localparam logic [7:0] SELECTOR_MASK = 8'h02;
    localparam logic [7:0] OUTCTL_RST    = 8'h00;
    localparam logic [7:0] PRESC_RST     = 8'h00;
    localparam logic [7:0] SELECTOR_RST  = 8'h00;

    // run mode encodings
    localparam logic [1:0] MODE_STOP   = 2'b00;
    localparam logic [1:0] MODE_FREE   = 2'b01;
    localparam logic [1:0] MODE_EDGE   = 2'b10;
    localparam logic [1:0] MODE_MATCH  = 2'b11;

    // valid edge encodings
    localparam logic [1:0] EDGE_FALL = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_BOTH = 2'b11;

    // count clock codes {group, select}
    localparam logic [2:0] CLK_FXX    = 3'b000;
    localparam logic [2:0] CLK_DIV4   = 3'b001;
    localparam logic [2:0] CLK_TICK   = 3'b010;
    localparam logic [2:0] CLK_PIN    = 3'b011;
    localparam logic [2:0] CLK_DIV2   = 3'b100;
    localparam logic [2:0] CLK_DIV8   = 3'b101;
    localparam logic [2:0] CLK_DIV16  = 3'b110;
    localparam int         DIV_W      = 4;
    // input pins are sampled at fxx/4
    localparam logic [1:0] SAMPLE_PHASE = 2'h3;

    // edge filter state
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic cand;
        logic level;
    } edge_state_s;

    // control block state
    typedef struct packed {
        logic [7:0]       presc;
        logic [7:0]       selc;
        logic [7:0]       outc;
        logic             level;
        logic             pin;
        logic             armed;
        logic             ran_before;
        logic             clr_start;
        logic             pirq;
        logic             sirq;
        logic [DIV_W-1:0] div;
        logic [31:0]      prdata;
        logic             pslverr;
    } ctl_state_s;

endpackage

`default_nettype wire

// ==== logic/edge_filter.sv ====
// two-sample noise filter and valid edge detector for one timer input pin
`default_nettype none

module edge_filter (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       pin_in,
    input  wire logic       sample_en,
    input  wire logic       hold,
    input  wire logic       prime_low,
    input  wire logic [1:0] edge_sel,
    output logic            valid_edge,
    output logic            level
);

    timer_out_pkg::edge_state_s st_r;
    timer_out_pkg::edge_state_s st_nxt;
    logic                       changed;
    logic                       rise_ok;
    logic                       fall_ok;

    // a new level is accepted only when two samples agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = pin_in;
        st_nxt.sync2 = st_r.sync1;
        changed = 1'b0;
        if (hold) begin
            // stopped: track the pin, or pretend it was low before the very first start
            st_nxt.level = prime_low ? 1'b0 : st_r.sync2;
            st_nxt.cand  = prime_low ? 1'b0 : st_r.sync2;
        end else if (sample_en) begin
            st_nxt.cand = st_r.sync2;
            if (st_r.sync2 == st_r.cand && st_r.sync2 != st_r.level) begin
                st_nxt.level = st_r.sync2;
                changed      = 1'b1;
            end
        end
    end

    // edge select decode; the prohibited code detects nothing
    assign rise_ok    = (edge_sel == timer_out_pkg::EDGE_RISE) ||
                        (edge_sel == timer_out_pkg::EDGE_BOTH);
    assign fall_ok    = (edge_sel == timer_out_pkg::EDGE_FALL) ||
                        (edge_sel == timer_out_pkg::EDGE_BOTH);
    assign valid_edge = changed && (st_nxt.level ? rise_ok : fall_ok);
    assign level      = st_r.level;

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

`default_nettype wire

// ==== dv/timer_output_and_count_clock_select_bench.sv ====
// self-checking bench for the timer output control and count clock selection block
`default_nettype none

module timer_output_and_count_clock_select_bench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [31:0] PRE   = timer_out_pkg::PRESCALER_IDX;
    localparam logic [31:0] SEL   = timer_out_pkg::SELECTOR_IDX;
    localparam logic [31:0] OUTC  = timer_out_pkg::OUTCTL_IDX;
    localparam logic [1:0]  STOP  = timer_out_pkg::MODE_STOP;
    localparam logic [1:0]  FREE  = timer_out_pkg::MODE_FREE;
    localparam logic [1:0]  EDGEM = timer_out_pkg::MODE_EDGE;
    localparam logic [1:0]  MATCH = timer_out_pkg::MODE_MATCH;

    logic        clk_sys;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  mode;
    logic        pmatch;
    logic        smatch;
    logic        itick;
    logic        ppin;
    logic        spin;
    logic        tout;
    logic        ctick;
    logic        cstart;
    logic        pedge;
    logic        sedge;
    logic        pirq;
    logic        sirq;
    logic [31:0] rd;
    logic        err;
    int          n_fail;
    int          total_checks;
    int          n_tick;
    int          n_cs;
    int          n_pe;
    int          n_se;

    timer_out_ctl u_timer_out_ctl (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .run_mode_hi(mode[1]), .run_mode_lo(mode[0]),
        .primary_match(pmatch), .secondary_match(smatch),
        .interval_timer_tick(itick), .primary_input_pin(ppin),
        .secondary_input_pin(spin), .timer_output_pin(tout), .count_tick(ctick),
        .counter_clear_start(cstart), .primary_valid_edge(pedge),
        .secondary_valid_edge(sedge), .primary_match_irq(pirq),
        .secondary_match_irq(sirq)
    );

    // 250 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // pulse counters; an output counts once per cycle it is high, so a steady fxx tick counts every cycle
    always @(posedge clk_sys) begin
        if (ctick === 1'b1) n_tick <= n_tick + 1;
        if (cstart === 1'b1) n_cs <= n_cs + 1;
        if (pedge === 1'b1) n_pe <= n_pe + 1;
        if (sedge === 1'b1) n_se <= n_se + 1;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [31:0] idx, input logic [7:0] d);
        int n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= idx << 2;
        pwdata  <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("pready seen", 32'h1, {31'h0, pready});
    endtask

    task automatic wr(input logic [31:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdchk(input string nm, input logic [31:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(nm, {24'h000000, e}, rd);
    endtask

    task automatic run(input logic [1:0] m);
        @(posedge clk_sys);
        mode <= m;
    endtask

    // bounded wait for the pin level, then compare it
    task automatic pin_is(input logic e);
        int n = 0;
        while (tout !== e && n < 8) begin
            @(posedge clk_sys);
            n++;
        end
        #1;
        chk("output pin", {31'h0, e}, {31'h0, tout});
    endtask

    // one-cycle match pulses; irqs and pin are judged one cycle later
    task automatic hit(input logic p, input logic s, input logic ep, input logic es,
                       input logic et);
        @(posedge clk_sys);
        pmatch <= p;
        smatch <= s;
        @(posedge clk_sys);
        pmatch <= 1'b0;
        smatch <= 1'b0;
        #1;
        chk("primary irq", {31'h0, ep}, {31'h0, pirq});
        chk("secondary irq", {31'h0, es}, {31'h0, sirq});
        chk("output pin", {31'h0, et}, {31'h0, tout});
    endtask

    // two full pin periods on both inputs, then a one-cycle glitch the filter must drop
    // every level of the two periods held 17 cycles
    task automatic wave();
        repeat (2) begin
            @(posedge clk_sys);
            ppin <= 1'b1;
            spin <= 1'b1;
            cyc(16);
            @(posedge clk_sys);
            ppin <= 1'b0;
            spin <= 1'b0;
            cyc(16);
        end
        @(posedge clk_sys);
        ppin <= 1'b1;
        spin <= 1'b1;
        @(posedge clk_sys);
        ppin <= 1'b0;
        spin <= 1'b0;
        cyc(16);
        #1;
    endtask

    // first run after reset with pins high reports a rise; a restart does not
    task automatic t_first();
        int p;
        int s;
        @(posedge clk_sys);
        ppin <= 1'b1;
        spin <= 1'b1;
        wr(PRE, 8'h50);
        #1 p = n_pe;
        s = n_se;
        run(FREE);
        cyc(24);
        #1 chk("first primary rise", p + 1, n_pe);
        chk("first secondary rise", s + 1, n_se);
        run(STOP);
        cyc(4);
        run(FREE);
        cyc(24);
        #1 chk("restart primary rise", p + 1, n_pe);
        chk("restart secondary rise", s + 1, n_se);
        run(STOP);
        ppin <= 1'b0;
        spin <= 1'b0;
        wr(PRE, 8'h00);
        $display("test first-enable edge done");
    endtask

    task automatic t_regs();
        rdchk("prescaler reset", PRE, 8'h00);
        rdchk("selector reset", SEL, 8'h00);
        rdchk("outctl reset", OUTC, 8'h00);
        wr(PRE, 8'hFF);
        rdchk("prescaler stored", PRE, 8'hF3);
        wr(SEL, 8'hFF);
        rdchk("selector stored", SEL, 8'h02);
        wr(SEL, 8'h00);
        wr(PRE, 8'h00);
        apb(1'b1, 32'h00000123, 8'hFF);
        chk("unmapped write error", 32'h1, {31'h0, err});
        apb(1'b0, 32'h00000123, 8'h00);
        chk("unmapped read data", 32'h0, rd);
        $display("test registers done");
    endtask

    task automatic t_level();
        wr(OUTC, 8'h12);
        pin_is(1'b0);
        wr(OUTC, 8'h13);
        wr(OUTC, 8'h1B);
        pin_is(1'b1);
        rdchk("level bits read", OUTC, 8'h13);
        wr(OUTC, 8'h13);
        cyc(4);
        pin_is(1'b1);
        wr(OUTC, 8'h1F);
        cyc(4);
        pin_is(1'b1);
        wr(OUTC, 8'h17);
        pin_is(1'b0);
        wr(OUTC, 8'h1B);
        pin_is(1'b1);
        wr(OUTC, 8'h12);
        pin_is(1'b0);
        $display("test output level done");
    endtask

    task automatic t_match();
        wr(OUTC, 8'h13);
        wr(OUTC, 8'h17);
        hit(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        run(FREE);
        hit(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        hit(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        hit(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        run(STOP);
        wr(OUTC, 8'h01);
        wr(OUTC, 8'h05);
        run(FREE);
        hit(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        hit(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        run(STOP);
        $display("test match inversion done");
    endtask

    task automatic t_oneshot();
        int c;
        wr(OUTC, 8'h33);
        wr(OUTC, 8'h37);
        run(FREE);
        hit(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        #1 c = n_cs;
        wr(OUTC, 8'h73);
        cyc(2);
        #1 chk("trigger clear start", c + 1, n_cs);
        rdchk("trigger reads zero", OUTC, 8'h33);
        hit(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        hit(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        hit(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        run(STOP);
        run(MATCH);
        hit(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        hit(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        run(STOP);
        $display("test one-shot done");
    endtask

    // internal clocks counted over a 64-cycle window, which every divider divides
    task automatic t_clock();
        logic [2:0] code [5] = '{3'b000, 3'b001, 3'b100, 3'b101, 3'b110};
        int         dv   [5] = '{1, 4, 2, 8, 16};
        int         c;
        for (int i = 0; i < 5; i++) begin
            wr(SEL, {6'h00, code[i][2], 1'b0});
            wr(PRE, {6'h00, code[i][1:0]});
            run(FREE);
            cyc(8);
            #1 c = n_tick;
            cyc(64);
            #1 chk("divided tick count", 64 / dv[i], n_tick - c);
            run(STOP);
        end
        wr(SEL, 8'h00);
        wr(PRE, 8'h02);
        run(FREE);
        cyc(4);
        #1 c = n_tick;
        repeat (5) begin
            @(posedge clk_sys);
            itick <= 1'b1;
            @(posedge clk_sys);
            itick <= 1'b0;
            cyc(2);
        end
        #1 chk("interval tick count", c + 5, n_tick);
        run(STOP);
        $display("test count clock done");
    endtask

    task automatic t_edges();
        logic [1:0] es [3] = '{2'b00, 2'b01, 2'b11};
        int         ex [3] = '{2, 2, 4};
        int         p;
        int         s;
        int         c;
        for (int i = 0; i < 3; i++) begin
            wr(PRE, {es[i], es[i], 4'h0});
            run(EDGEM);
            cyc(16);
            #1 p = n_pe;
            s = n_se;
            c = n_cs;
            wave();
            chk("primary edges", p + ex[i], n_pe);
            chk("secondary edges", s + ex[i], n_se);
            chk("edge clear start", c + ex[i], n_cs);
            run(STOP);
        end
        wr(PRE, 8'h13);
        run(FREE);
        cyc(16);
        #1 c = n_tick;
        wave();
        chk("pin clock ticks", c + 2, n_tick);
        run(STOP);
        $display("test valid edges done");
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // the whole run needs about a thousand cycles; this cuts a hang short
    initial begin
        #200000;
        n_fail++;
        $display("watchdog expired");
        close_out();
    end

    initial begin
        {rst_n, psel, penable, pwrite, pmatch, smatch, itick, ppin, spin} = '0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        mode = 2'b00;
        {n_fail, total_checks, n_tick, n_cs, n_pe, n_se} = '0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_first();
        t_regs();
        t_level();
        t_match();
        t_oneshot();
        t_clock();
        t_edges();
        close_out();
    end
endmodule

`default_nettype wire
